// ===== fspr_fwd_decide.sv
// registered forwarding decision for one class of unknown packet
`timescale 1ns/1ns
module fspr_fwd_decide (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// configuration
	input wire logic i_en,
	input wire logic [4:0] i_map,
	// decision request and answer
	input wire logic i_req,
	output fspr_pkg::fspr_dec_state_t o_dec
);

	fspr_pkg::fspr_dec_state_t st_ff;
	fspr_pkg::fspr_dec_state_t nxt_st;

	// result held until the next request; valid is one cycle
	always_comb begin
		nxt_st = st_ff;
		nxt_st.valid = i_req;
		if (i_req) begin
			nxt_st.res = fspr_pkg::fspr_decode_map(i_en, i_map);
		end
	end

	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_dec = st_ff;

endmodule

// ===== fspr_map_mem.sv
// priority map storage: 16 bytes of 2-bit entries, two read ports
`timescale 1ns/1ns
module fspr_map_mem (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// register-side write and read
	input wire logic i_wr,
	input wire logic [3:0] i_waddr,
	input wire logic [7:0] i_wdata,
	input wire logic [3:0] i_raddr,
	output logic [7:0] o_rdata,
	// lookup by the upper six bits of the tos byte
	input wire logic i_look,
	input wire logic [5:0] i_code,
	output logic [1:0] o_prio,
	output logic o_prio_valid
);

	fspr_pkg::fspr_mem_state_t st_ff;
	fspr_pkg::fspr_mem_state_t nxt_st;

	// write last in the copy, reads see the stored (old) value
	always_comb begin
		logic [7:0] w;
		w = st_ff.word[i_code[5:2]];
		nxt_st = st_ff;
		nxt_st.rdata = st_ff.word[i_raddr];
		nxt_st.prio_valid = i_look;
		nxt_st.prio = w[{i_code[1:0], 1'b0} +: 2];
		if (i_wr) begin
			nxt_st.word[i_waddr] = i_wdata;
		end
	end

	// every entry clears to zero at reset
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign o_rdata = st_ff.rdata;
	assign o_prio = st_ff.prio;
	assign o_prio_valid = st_ff.prio_valid;

endmodule

// ===== fspr_pkg.sv
// shared constants, carrier types and the port-map decoder
package fspr_pkg;

	// clock rate, in kHz, so that ms times become cycles directly
	localparam int unsigned CLK_KHZ = 250000;

	// ingress rate-limit unit periods, in ms as printed
	localparam int unsigned PERIOD_SHORT_MS = 16;
	localparam int unsigned PERIOD_MID_MS = 64;
	localparam int unsigned PERIOD_LONG_MS = 256;
	localparam int unsigned CYC_SHORT = PERIOD_SHORT_MS * CLK_KHZ;
	localparam int unsigned CYC_MID = PERIOD_MID_MS * CLK_KHZ;
	localparam int unsigned CYC_LONG = PERIOD_LONG_MS * CLK_KHZ;
	localparam int unsigned CNT_W = 26;

	// register offsets on the management port
	localparam logic [7:0] ADDR_UNK_VID = 8'h85;
	localparam logic [7:0] ADDR_SELF_IPMC = 8'h86;
	localparam logic [7:0] ADDR_RATE_TAG = 8'h87;
	localparam logic [7:0] ADDR_MAP_FIRST = 8'h90;
	localparam logic [7:0] ADDR_MAP_LAST = 8'h9F;
	localparam int unsigned MAP_REGS = 16;

	// field positions
	localparam int unsigned FWD_EN_BIT = 5;
	localparam int unsigned SELF_FLT_BIT = 6;
	localparam int unsigned PERIOD_LSB = 4;
	localparam int unsigned QUEUE_BIT = 3;
	localparam int unsigned TAG_SEL_BIT = 2;
	localparam int unsigned MAP_MSB = 4;

	// reset values
	localparam logic [4:0] RST_MAP5 = 5'h00;
	localparam logic [1:0] RST_PERIOD = 2'h1;
	localparam logic [7:0] RST_TOS_MAP = 8'h00;

	// period field encodings; upper bit set means the long period
	localparam logic [1:0] PERIOD_SHORT = 2'h0;
	localparam logic [1:0] PERIOD_MID = 2'h1;

	// register access request from the management interface
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} fspr_reg_req_t;

	// forwarding decision for one class of unknown packet
	typedef struct packed {
		logic override;
		logic filter;
		logic [3:0] mask;
	} fspr_fwd_res_t;

	typedef struct packed {
		logic valid;
		fspr_fwd_res_t res;
	} fspr_dec_state_t;

	typedef struct packed {
		logic [MAP_REGS-1:0][7:0] word;
		logic [7:0] rdata;
		logic [1:0] prio;
		logic prio_valid;
	} fspr_mem_state_t;

	typedef struct packed {
		logic [4:0] vid_map;
		logic vid_en;
		logic [4:0] ipmc_map;
		logic ipmc_en;
		logic self_en;
		logic [1:0] period;
		logic queue_en;
		logic tag_sel;
		logic rd_pend;
		logic rd_is_map;
		logic [7:0] rd_ctrl;
		logic [7:0] rdata;
		logic rvalid;
		logic [CNT_W-1:0] cnt;
		logic tick;
		logic self_drop;
		logic self_valid;
		logic tag_insert;
		logic tag_valid;
	} fspr_state_t;

	// five-bit map: bits 4:1 are ports 4..1, bit 0 is ignored
	function automatic fspr_fwd_res_t fspr_decode_map(input logic en, input logic [4:0] map);
		fspr_fwd_res_t r;
		r.override = en;
		r.mask = en ? map[4:1] : 4'h0;
		// 00000 filters; 00001 is reserved and also filters
		r.filter = en && (map[4:1] == 4'h0);
		return r;
	endfunction

endpackage

// ===== fspr_regs.sv
// forwarding policy registers: unknown packets, self filter, rate, tos map
// Functional notes
// - unknown-VID enable bit 5 lets the unknown-VID map steer forwarding
// - map 00000/00001 filter, bits 4:1 select ports 4..1, bit 0 ignored
// - unknown IP multicast enable uses its own map, decoded the same way
// - self filter enable bit 6 drops own-address packets at egress
// - own MAC address comes from the address registers 104-109
// - period field: 00 16ms, 01 64ms, 1x 256ms; resets to 01
// - bit 3 set gives per-queue egress limiting, clear gives per-port
// - bit 2 picks per-source tag insertion, else port control 0 bit 2
// - 64 two-bit entries, indexed by upper six TOS bits, give priority
// - code 0x02 uses bits 5:4, code 0x01 uses bits 3:2, reset zero
// - later map registers continue the pattern up to code 0x3F
`timescale 1ns/1ns
module fspr_regs #(
	parameter int unsigned P_CYC_SHORT = fspr_pkg::CYC_SHORT,
	parameter int unsigned P_CYC_MID = fspr_pkg::CYC_MID,
	parameter int unsigned P_CYC_LONG = fspr_pkg::CYC_LONG
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// management register port
	input fspr_pkg::fspr_reg_req_t i_reg,
	output logic [7:0] o_reg_rdata,
	output logic o_reg_rvalid,
	// unknown packet decisions: index 0 unknown VID, 1 unknown IP multicast
	input wire logic [1:0] i_unk_req,
	output fspr_pkg::fspr_dec_state_t o_unk_dec [2],
	// self-address check at the egress port
	input wire logic [47:0] i_self_mac,
	input wire logic i_self_chk,
	input wire logic [47:0] i_egr_da,
	output logic o_self_drop,
	output logic o_self_valid,
	// tos priority lookup
	input wire logic i_tos_req,
	input wire logic [7:0] i_tos,
	output logic [1:0] o_prio,
	output logic o_prio_valid,
	// tag insertion decision
	input wire logic i_tag_req,
	input wire logic [1:0] i_tag_src,
	input wire logic [3:0] i_ctrl8_insert,
	input wire logic [3:0] i_ctrl0_insert,
	output logic o_tag_insert,
	output logic o_tag_valid,
	// rate-limit controls
	output logic o_period_tick,
	output logic [1:0] o_period_sel,
	output logic o_queue_egress,
	output logic o_tag_per_source
);

	// port timing, all on the rising edge:
	// - a write lands at its own edge; the field shows from the next cycle
	// - a read is taken at its edge and answered with o_reg_rvalid two edges later
	// - reads and writes may come every cycle; answers leave in request order
	// - a read and a write at one edge: the read returns the old byte
	// - decisions, self check, tos lookup and tag pick answer one edge later
	// - each valid is a one-cycle pulse; results hold until the next request, except o_prio, which follows i_tos every cycle
	// - a tos lookup sees the map as it stood before a write at the same edge
	// unit period:
	// - the counter runs 0..N-1 and the tick pulses once every N cycles
	// - any write to the period register restarts the count from zero
	// - real periods are millions of cycles, so tests shrink the parameters
	// limits:
	// - reserved and unmapped bits read as zero and ignore writes
	// - map code 00001 is taken as a filter, the same as 00000
	// - a disabled class reports no override and leaves handling to the datapath

	fspr_pkg::fspr_state_t st_ff;
	fspr_pkg::fspr_state_t nxt_st;

	// map memory hookup
	logic map_wr;
	logic [3:0] map_waddr;
	logic [3:0] map_raddr;
	logic [7:0] map_rdata;
	logic [1:0] map_prio;
	logic map_prio_valid;

	// per-class configuration for the decision units
	logic [1:0] unk_en;
	logic [4:0] unk_map [2];

	// shared register decode
	logic wr_rate;
	logic rd_map;
	logic [7:0] rd_image;

	// address window test, used for both write and read
	function automatic logic in_map(input logic [7:0] a);
		return (a >= fspr_pkg::ADDR_MAP_FIRST) && (a <= fspr_pkg::ADDR_MAP_LAST);
	endfunction

	// byte image of a control register; reserved bits read as zero
	function automatic logic [7:0] ctrl_image(input fspr_pkg::fspr_state_t s,
		input logic [7:0] a);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			// enable over the five-bit map
			fspr_pkg::ADDR_UNK_VID: begin
				d[fspr_pkg::FWD_EN_BIT] = s.vid_en;
				d[fspr_pkg::MAP_MSB:0] = s.vid_map;
			end
			// self filter, then enable over the map
			fspr_pkg::ADDR_SELF_IPMC: begin
				d[fspr_pkg::SELF_FLT_BIT] = s.self_en;
				d[fspr_pkg::FWD_EN_BIT] = s.ipmc_en;
				d[fspr_pkg::MAP_MSB:0] = s.ipmc_map;
			end
			// period, queue mode and tag selection
			fspr_pkg::ADDR_RATE_TAG: begin
				d[fspr_pkg::PERIOD_LSB +: 2] = s.period;
				d[fspr_pkg::QUEUE_BIT] = s.queue_en;
				d[fspr_pkg::TAG_SEL_BIT] = s.tag_sel;
			end
			default: begin
				d = 8'h00;
			end
		endcase
		return d;
	endfunction

	// last count of the selected unit period
	function automatic logic [fspr_pkg::CNT_W-1:0] period_last(input logic [1:0] p);
		logic [fspr_pkg::CNT_W-1:0] n;
		case (p)
			fspr_pkg::PERIOD_SHORT: n = fspr_pkg::CNT_W'(P_CYC_SHORT - 1);
			fspr_pkg::PERIOD_MID: n = fspr_pkg::CNT_W'(P_CYC_MID - 1);
			default: n = fspr_pkg::CNT_W'(P_CYC_LONG - 1);
		endcase
		return n;
	endfunction

	// map writes and reads go straight to the memory, index = offset - first
	always_comb begin
		map_wr = i_reg.wr && in_map(i_reg.addr);
		map_waddr = i_reg.addr[3:0];
		map_raddr = i_reg.addr[3:0];
	end

	// shared address decode; the read image is taken before any same-edge write
	always_comb begin
		wr_rate = i_reg.wr && (i_reg.addr == fspr_pkg::ADDR_RATE_TAG);
		rd_map = in_map(i_reg.addr);
		rd_image = ctrl_image(st_ff, i_reg.addr);
	end

	// next state of all control fields and pipelines
	always_comb begin
		nxt_st = st_ff;
		// tick is a one-cycle pulse unless the period ends below
		nxt_st.tick = 1'b0;

		// writes touch only writable fields; reserved bits stay at default
		if (i_reg.wr) begin
			case (i_reg.addr)
				// unknown VID class
				fspr_pkg::ADDR_UNK_VID: begin
					nxt_st.vid_en = i_reg.wdata[fspr_pkg::FWD_EN_BIT];
					nxt_st.vid_map = i_reg.wdata[fspr_pkg::MAP_MSB:0];
				end
				// self filter and unknown IP multicast class
				fspr_pkg::ADDR_SELF_IPMC: begin
					nxt_st.self_en = i_reg.wdata[fspr_pkg::SELF_FLT_BIT];
					nxt_st.ipmc_en = i_reg.wdata[fspr_pkg::FWD_EN_BIT];
					nxt_st.ipmc_map = i_reg.wdata[fspr_pkg::MAP_MSB:0];
				end
				// rate-limit and tag controls
				fspr_pkg::ADDR_RATE_TAG: begin
					nxt_st.period = i_reg.wdata[fspr_pkg::PERIOD_LSB +: 2];
					nxt_st.queue_en = i_reg.wdata[fspr_pkg::QUEUE_BIT];
					nxt_st.tag_sel = i_reg.wdata[fspr_pkg::TAG_SEL_BIT];
				end
				default: begin
					nxt_st.vid_en = st_ff.vid_en;
				end
			endcase
		end

		// read: capture in cycle 1, present in cycle 2 for every address
		nxt_st.rd_pend = i_reg.rd;
		if (i_reg.rd) begin
			nxt_st.rd_is_map = rd_map;
			nxt_st.rd_ctrl = rd_image;
		end
		// answer stage: the memory byte has had one cycle to come out
		nxt_st.rvalid = st_ff.rd_pend;
		if (st_ff.rd_pend) begin
			if (st_ff.rd_is_map) begin
				nxt_st.rdata = map_rdata;
			end else begin
				nxt_st.rdata = st_ff.rd_ctrl;
			end
		end

		// free-running unit period; a new period value restarts the count
		if (wr_rate) begin
			// restart so that a new period starts whole
			nxt_st.cnt = '0;
		end else if (st_ff.cnt >= period_last(st_ff.period)) begin
			// last count of the period: wrap and pulse
			nxt_st.cnt = '0;
			nxt_st.tick = 1'b1;
		end else begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end

		// own-address compare; the address itself lives in 104-109
		nxt_st.self_valid = i_self_chk;
		if (i_self_chk) begin
			if (st_ff.self_en && (i_egr_da == i_self_mac)) begin
				nxt_st.self_drop = 1'b1;
			end else begin
				nxt_st.self_drop = 1'b0;
			end
		end

		// tag insertion: per source from control 8, else control 0 bit 2
		nxt_st.tag_valid = i_tag_req;
		if (i_tag_req) begin
			if (st_ff.tag_sel) begin
				nxt_st.tag_insert = i_ctrl8_insert[i_tag_src];
			end else begin
				nxt_st.tag_insert = i_ctrl0_insert[i_tag_src];
			end
		end
	end

	// control state and pipelines
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			st_ff <= '0;
			// fields whose defaults come from the package
			st_ff.vid_map <= fspr_pkg::RST_MAP5;
			st_ff.ipmc_map <= fspr_pkg::RST_MAP5;
			st_ff.period <= fspr_pkg::RST_PERIOD;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// priority map memory; lookups see the code in tos bits 7:2
	fspr_map_mem u_map (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_wr(map_wr),
		.i_waddr(map_waddr),
		.i_wdata(i_reg.wdata),
		.i_raddr(map_raddr),
		.o_rdata(map_rdata),
		.i_look(i_tos_req),
		.i_code(i_tos[7:2]),
		.o_prio(map_prio),
		.o_prio_valid(map_prio_valid)
	);

	// configuration of the two unknown-packet classes
	always_comb begin
		unk_en[0] = st_ff.vid_en;
		unk_map[0] = st_ff.vid_map;
		unk_en[1] = st_ff.ipmc_en;
		unk_map[1] = st_ff.ipmc_map;
	end

	// one decision unit per class; both share the same map decoding
	for (genvar g = 0; g < 2; g++) begin : g_unk
		fspr_fwd_decide u_dec (
			.i_clk(i_clk),
			.i_nrst(i_nrst),
			.i_en(unk_en[g]),
			.i_map(unk_map[g]),
			.i_req(i_unk_req[g]),
			.o_dec(o_unk_dec[g])
		);
	end

	// register port answer
	assign o_reg_rdata = st_ff.rdata;
	assign o_reg_rvalid = st_ff.rvalid;

	// egress self-address verdict
	assign o_self_drop = st_ff.self_drop;
	assign o_self_valid = st_ff.self_valid;

	// priority straight from the memory's output register
	assign o_prio = map_prio;
	assign o_prio_valid = map_prio_valid;

	// tag insertion verdict
	assign o_tag_insert = st_ff.tag_insert;
	assign o_tag_valid = st_ff.tag_valid;

	// rate-limit tick and levels, all from flip-flops
	assign o_period_tick = st_ff.tick;
	assign o_period_sel = st_ff.period;
	assign o_queue_egress = st_ff.queue_en;
	assign o_tag_per_source = st_ff.tag_sel;

endmodule

// ===== fspr_regs_bench.sv
// self-checking bench for the forwarding policy registers
`timescale 1ns/1ns
module fspr_regs_bench;
	localparam int unsigned S = 16;
	localparam int unsigned M = 64;
	localparam int unsigned L = 256;
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	fspr_pkg::fspr_reg_req_t i_reg = '0;
	logic [1:0] i_unk_req = 2'h0;
	logic [47:0] i_self_mac = 48'h0;
	logic [47:0] i_egr_da = 48'h0;
	logic i_self_chk = 1'b0;
	logic i_tos_req = 1'b0;
	logic [7:0] i_tos = 8'h00;
	logic i_tag_req = 1'b0;
	logic [1:0] i_tag_src = 2'h0;
	logic [3:0] i_ctrl8_insert = 4'h0;
	logic [3:0] i_ctrl0_insert = 4'h0;
	logic [7:0] o_reg_rdata;
	logic o_reg_rvalid, o_self_drop, o_self_valid, o_prio_valid, o_tag_insert, o_tag_valid;
	logic o_period_tick, o_queue_egress, o_tag_per_source;
	logic [1:0] o_prio, o_period_sel;
	fspr_pkg::fspr_dec_state_t o_unk_dec [2];
	logic [7:0] msk [4] = '{8'h3F, 8'h7F, 8'h3C, 8'h00};
	int errors = 0;
	int n_tests = 0;
	int seed = 32'hfeaadf06;
	int mdl [16];
	int i, k, g;
	logic [7:0] r;
	logic [4:0] m;
	always #2 i_clk = ~i_clk;
	fspr_regs #(.P_CYC_SHORT(S), .P_CYC_MID(M), .P_CYC_LONG(L)) dut (.i_clk, .i_nrst, .i_reg,
		.o_reg_rdata, .o_reg_rvalid, .i_unk_req, .o_unk_dec, .i_self_mac, .i_self_chk, .i_egr_da,
		.o_self_drop, .o_self_valid, .i_tos_req, .i_tos, .o_prio, .o_prio_valid, .i_tag_req,
		.i_tag_src, .i_ctrl8_insert, .i_ctrl0_insert, .o_tag_insert, .o_tag_valid,
		.o_period_tick, .o_period_sel, .o_queue_egress, .o_tag_per_source);
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, errors);
		if (errors == 0 && n_tests > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// map bytes are mirrored in the model as they are written
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge i_clk);
		i_reg = {2'b10, a, d};
		@(negedge i_clk);
		i_reg = '0;
		if (a[7:4] == 4'h9) mdl[a[3:0]] = d;
	endtask
	// answer lands two cycles after the request edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(negedge i_clk);
		i_reg = {2'b01, a, 8'h00};
		@(negedge i_clk);
		i_reg = '0;
		@(negedge i_clk);
		check({o_reg_rvalid, o_reg_rdata}, {1'b1, exp});
	endtask
	// one request pulse: tag, tos, self, ipmc, vid
	task automatic fire(input logic [4:0] q);
		@(negedge i_clk);
		{i_tag_req, i_tos_req, i_self_chk, i_unk_req} = q;
		@(negedge i_clk);
		{i_tag_req, i_tos_req, i_self_chk, i_unk_req} = 5'h00;
	endtask
	function automatic logic [5:0] dec(input logic en, input logic [4:0] mp);
		return {en, en && mp[4:1] == 4'h0, en ? mp[4:1] : 4'h0};
	endfunction
	initial begin
		repeat (2) @(negedge i_clk);
		i_nrst = 1'b1;
		check(o_period_sel, 2'h1);
		rd(8'h87, 8'h10);
		rd(8'h9F, 8'h00);
		// reserved bits and the unmapped 0x88 never stick
		for (k = 0; k < 4; k++) begin
			rd(8'h85 + 8'(k), 8'h00 | {1'b0, k == 2, 4'h0});
			r = 8'($random(seed));
			wr(8'h85 + 8'(k), r);
			rd(8'h85 + 8'(k), r & msk[k]);
		end
		// every map code with the enable off and on
		for (i = 0; i < 64; i++) begin
			m = 5'(i);
			wr(8'h85, 8'(i));
			wr(8'h86, {2'b00, ~i[5], ~m});
			fire(5'h03);
			check({o_unk_dec[0].valid, o_unk_dec[0].res}, {1'b1, dec(i[5], m)});
			check({o_unk_dec[1].valid, o_unk_dec[1].res}, {1'b1, dec(~i[5], ~m)});
		end
		for (k = 0; k < 8; k++) begin
			wr(8'h86, {1'b0, k[1], 6'h00});
			i_self_mac = 48'({$random(seed), $random(seed)});
			i_egr_da = k[0] ? i_self_mac : i_self_mac ^ (48'h1 << (6 * k));
			fire(5'h04);
			check({o_self_valid, o_self_drop}, {1'b1, k[1] & k[0]});
		end
		for (k = 0; k < 16; k++) wr(8'h90 + 8'(k), 8'($random(seed)));
		for (k = 0; k < 16; k++) rd(8'h90 + 8'(k), 8'(mdl[k]));
		for (k = 0; k < 64; k++) begin
			i_tos = {k[5:0], 2'($random(seed))};
			fire(5'h08);
			check({o_prio_valid, o_prio}, {1'b1, 2'(mdl[k / 4] >> (2 * (k % 4)))});
		end
		for (k = 0; k < 16; k++) begin
			wr(8'h87, {2'b00, k[1:0], k[2], k[3], 2'b00});
			check({o_period_sel, o_queue_egress, o_tag_per_source}, {k[1:0], k[2], k[3]});
			i_tag_src = 2'($random(seed));
			{i_ctrl8_insert, i_ctrl0_insert} = 8'($random(seed));
			fire(5'h10);
			check({o_tag_valid, o_tag_insert},
				{1'b1, k[3] ? i_ctrl8_insert[i_tag_src] : i_ctrl0_insert[i_tag_src]});
		end
		// tick spacing for every period code, bounded waits
		for (k = 0; k < 4; k++) begin
			wr(8'h87, 8'(k << 4));
			g = 0;
			while (o_period_tick !== 1'b1 && g < 600) begin
				@(negedge i_clk);
				g++;
			end
			g = 0;
			do begin
				@(negedge i_clk);
				g++;
			end while (o_period_tick !== 1'b1 && g < 600);
			check(16'(g), 16'((k == 0) ? S : (k == 1) ? M : L));
		end
		i_nrst = 1'b0;
		repeat (2) @(negedge i_clk);
		i_nrst = 1'b1;
		rd(8'h87, 8'h10);
		complete_run();
	end
	initial begin
		#200000;
		errors++;
		complete_run();
	end
endmodule

// ===== fspr_regs_checker.sv
// port assertions for the forwarding policy registers
`timescale 1ns/1ns
module fspr_regs_checker #(
	parameter int unsigned P_CYC_SHORT = 16,
	parameter int unsigned P_CYC_MID = 64,
	parameter int unsigned P_CYC_LONG = 256
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input fspr_pkg::fspr_reg_req_t i_reg,
	input wire logic [7:0] o_reg_rdata,
	input wire logic o_reg_rvalid,
	input wire logic [1:0] i_unk_req,
	input fspr_pkg::fspr_dec_state_t o_unk_dec [2],
	input wire logic [47:0] i_self_mac,
	input wire logic i_self_chk,
	input wire logic [47:0] i_egr_da,
	input wire logic o_self_drop,
	input wire logic o_self_valid,
	input wire logic i_tos_req,
	input wire logic o_prio_valid,
	input wire logic i_tag_req,
	input wire logic [1:0] i_tag_src,
	input wire logic [3:0] i_ctrl8_insert,
	input wire logic [3:0] i_ctrl0_insert,
	input wire logic o_tag_insert,
	input wire logic o_tag_valid,
	input wire logic o_period_tick,
	input wire logic [1:0] o_period_sel,
	input wire logic o_queue_egress,
	input wire logic o_tag_per_source
);
	logic [31:0] gap_ff;
	logic armed_ff;
	logic self_en_ff;
	logic [5:0] vid_cfg_ff;
	logic [5:0] ipmc_cfg_ff;
	logic [5:0] vid_exp;
	logic [5:0] ipmc_exp;
	logic wr_rate;
	logic tag_exp;
	logic self_hit;
	logic [3:0] wfield;
	int unsigned period_n;
	// helper terms sampled by the properties
	assign wr_rate = i_reg.wr && (i_reg.addr == fspr_pkg::ADDR_RATE_TAG);
	assign tag_exp = o_tag_per_source ? i_ctrl8_insert[i_tag_src] : i_ctrl0_insert[i_tag_src];
	assign self_hit = i_egr_da == i_self_mac;
	assign wfield = i_reg.wdata[5:2];
	// expected decisions from the mirrored enable and map bits
	assign vid_exp = {vid_cfg_ff[5], vid_cfg_ff[5] && (vid_cfg_ff[4:1] == 4'h0),
		vid_cfg_ff[5] ? vid_cfg_ff[4:1] : 4'h0};
	assign ipmc_exp = {ipmc_cfg_ff[5], ipmc_cfg_ff[5] && (ipmc_cfg_ff[4:1] == 4'h0),
		ipmc_cfg_ff[5] ? ipmc_cfg_ff[4:1] : 4'h0};
	assign period_n = (o_period_sel == 2'h0) ? P_CYC_SHORT :
		(o_period_sel == 2'h1) ? P_CYC_MID : P_CYC_LONG;
	// a restart write spoils the gap, so only whole periods are judged
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			gap_ff <= 32'h00000000;
			armed_ff <= 1'b0;
			self_en_ff <= 1'b0;
			vid_cfg_ff <= 6'h00;
			ipmc_cfg_ff <= 6'h00;
		end else begin
			gap_ff <= o_period_tick ? 32'h00000000 : gap_ff + 32'h00000001;
			armed_ff <= wr_rate ? 1'b0 : (o_period_tick | armed_ff);
			if (i_reg.wr && i_reg.addr == fspr_pkg::ADDR_UNK_VID) begin
				vid_cfg_ff <= i_reg.wdata[5:0];
			end
			if (i_reg.wr && i_reg.addr == fspr_pkg::ADDR_SELF_IPMC) begin
				self_en_ff <= i_reg.wdata[6];
				ipmc_cfg_ff <= i_reg.wdata[5:0];
			end
		end
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	resv_vid_a: assert property ((i_reg.rd && i_reg.addr == 8'h85) |-> ##2
		(o_reg_rvalid && o_reg_rdata[7:6] == 2'h0)) else $error("bad 0x85 read");
	resv_rate_a: assert property ((i_reg.rd && i_reg.addr == 8'h87) |-> ##2
		(o_reg_rvalid && o_reg_rdata[7:6] == 2'h0 && o_reg_rdata[1:0] == 2'h0))
		else $error("bad 0x87 read");
	vid_dec_a: assert property (i_unk_req[0] |=> (o_unk_dec[0].valid &&
		o_unk_dec[0].res == $past(vid_exp))) else $error("bad vid decision");
	ipmc_dec_a: assert property (i_unk_req[1] |=> (o_unk_dec[1].valid &&
		o_unk_dec[1].res == $past(ipmc_exp))) else $error("bad ipmc decision");
	self_drop_a: assert property (i_self_chk |=> (o_self_valid &&
		o_self_drop == ($past(self_hit) && $past(self_en_ff)))) else $error("bad self drop");
	rate_field_a: assert property (wr_rate |=>
		({o_period_sel, o_queue_egress, o_tag_per_source} == $past(wfield)))
		else $error("bad rate fields");
	tick_gap_a: assert property ((o_period_tick && armed_ff) |->
		(32'(gap_ff) == period_n - 1)) else $error("bad tick gap");
	tag_pick_a: assert property (i_tag_req |=>
		(o_tag_valid && o_tag_insert == $past(tag_exp))) else $error("bad tag pick");
	prio_resp_a: assert property (i_tos_req |=> o_prio_valid)
		else $error("no prio answer");
	cover property (o_period_tick && armed_ff);
	cover property (o_unk_dec[0].valid && o_unk_dec[0].res.filter);
	cover property (o_self_valid && o_self_drop);
endmodule
bind fspr_regs fspr_regs_checker #(.P_CYC_SHORT(P_CYC_SHORT), .P_CYC_MID(P_CYC_MID),
	.P_CYC_LONG(P_CYC_LONG)) u_chk (.*);
